// ==== design/crf_pkg.sv ====
// Purpose: constants and types for the processor register file and status word
// Assumes: one core clock, asynchronous active-low reset
// Notes: status word layout is trace, supervisor, 3-bit mask, five flags
//
// Overview of operation
// RQ1 - Sixteen 32-bit general registers and a 32-bit program counter are held.
// RQ2 - Data registers are written and read at byte, word or long size chosen per access.
// RQ3 - A write to a data register may update the condition flags from the result.
// RQ4 - Address registers and the stack pointer take only word or long writes and keep flags.
// RQ5 - Address registers and the stack pointer serve as stack pointers and base addresses.
// RQ6 - Any data or address register can be chosen as the index source.
// RQ7 - The status word upper byte and supervisor stack pointer are reachable only in supervisor.
// RQ8 - The status word holds a 3-bit interrupt mask giving eight levels.
// RQ9 - The status word holds extend, negative, zero, overflow and carry flags.
// RQ10 - The status word holds a trace bit and a supervisor-state bit.
// RQ11 - The stack pointer resolves to the supervisor one in supervisor state, else the user one.
package crf_pkg;

    typedef enum logic [1:0] {
        CRF_SZ_BYTE,
        CRF_SZ_WORD,
        CRF_SZ_LONG
    } crf_size_t;

    localparam int CRF_NUM_DATA = 8;
    localparam int CRF_NUM_ADDR = 7;
    localparam logic [3:0] CRF_SP_SEL = 4'hf;
    localparam logic [2:0] CRF_SP_BASE = 3'h7;

    // status word field positions
    localparam int CRF_SW_T_BIT = 15;
    localparam int CRF_SW_S_BIT = 13;
    localparam int CRF_SW_MASK_LSB = 8;
    localparam int CRF_SW_MASK_MSB = 10;
    localparam int CRF_SW_FLAGS_MSB = 4;
    localparam int CRF_SW_X_BIT = 4;
    localparam int CRF_SW_N_BIT = 3;
    localparam int CRF_SW_Z_BIT = 2;
    localparam int CRF_SW_V_BIT = 1;
    localparam int CRF_SW_C_BIT = 0;

    localparam logic [15:0] CRF_SW_RESET = 16'h2700;
    localparam logic [15:0] CRF_SW_ALL_BITS = 16'ha71f;
    localparam logic [7:0] CRF_SW_LOW_BITS = 8'h1f;

    localparam logic [31:0] CRF_REG_RESET = 32'h0000_0000;

endpackage

// ==== design/crf_sw_if.sv ====
// Purpose: link between register core and status word unit
// Assumes: same clock on both sides
// Notes: status word driven from a flip-flop in the unit
`timescale 1ns/10ps
interface crf_sw_if;
    logic flag_we;
    logic [4:0] flags;
    logic sw_we;
    logic sw_full;
    logic [15:0] sw_data;
    logic [15:0] status_word;

    modport core (
        output flag_we,
        output flags,
        output sw_we,
        output sw_full,
        output sw_data,
        input status_word
    );

    modport unit (
        input flag_we,
        input flags,
        input sw_we,
        input sw_full,
        input sw_data,
        output status_word
    );
endinterface

// ==== design/crf_status.sv ====
// Purpose: status word with mask, flags, trace and supervisor bits
// Assumes: whole-word writes only honoured in supervisor state
// Notes: an explicit status write wins over a flag update in the same cycle
`timescale 1ns/10ps
module crf_status (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // core link
    crf_sw_if.unit swi
);
    import crf_pkg::*;

    logic [15:0] sw_q;
    logic sup;

    assign sup = sw_q[CRF_SW_S_BIT];
    assign swi.status_word = sw_q;

    // ----------------------------------------
    // status word register
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sw_q <= CRF_SW_RESET; // see RQ10
        end else if (swi.sw_we) begin
            if (swi.sw_full) begin
                if (sup) begin
                    sw_q <= swi.sw_data & CRF_SW_ALL_BITS; // see RQ7 see RQ8 see RQ10
                end
            end else begin
                sw_q[7:0] <= swi.sw_data[7:0] & CRF_SW_LOW_BITS;
            end
        end else if (swi.flag_we) begin
            sw_q[CRF_SW_FLAGS_MSB:0] <= swi.flags; // see RQ9
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_user_full_write;
        swi.sw_we && swi.sw_full && !sup;
    endsequence

    sequence s_sup_full_write;
        swi.sw_we && swi.sw_full && sup;
    endsequence

    a_user_upper_locked: assert property ( // see RQ7
        s_user_full_write |=> $stable(sw_q))
        else $error("user-state status write changed the status word");

    a_mask_write_taken: assert property ( // see RQ8
        s_sup_full_write |=> sw_q[CRF_SW_MASK_MSB:CRF_SW_MASK_LSB] == $past(swi.sw_data[10:8]))
        else $error("interrupt mask not taken from supervisor write");

    a_flags_loaded: assert property ( // see RQ9
        swi.flag_we && !swi.sw_we |=> sw_q[4:0] == $past(swi.flags) && $stable(sw_q[15:8]))
        else $error("flag update not reflected in status word");
endmodule

// ==== design/crf_top.sv ====
// Purpose: programmer-visible register set of the processor core
// Assumes: results and flags come from the execution unit already computed
// Notes: all reads registered, answer one cycle after the request
`timescale 1ns/10ps
module crf_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register write
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire crf_pkg::crf_size_t wr_size,
    input wire logic [31:0] wr_data,
    input wire logic wr_flags_en,
    input wire logic [4:0] wr_flags,
    // program counter
    input wire logic pc_load,
    input wire logic [31:0] pc_data,
    // status word write
    input wire logic sw_wr_en,
    input wire logic sw_wr_full,
    input wire logic [15:0] sw_wr_data,
    // operand, index and base reads
    input wire logic [3:0] rd_sel,
    input wire crf_pkg::crf_size_t rd_size,
    input wire logic [3:0] idx_sel,
    input wire logic idx_long,
    input wire logic [2:0] base_sel,
    // results
    output logic [31:0] rd_data_q,
    output logic [31:0] index_q,
    output logic [31:0] base_addr_q,
    output logic [31:0] pc_q,
    output logic [15:0] status_word_q,
    output logic supervisor_q,
    output logic size_fault_q,
    output logic priv_fault_q
);
    import crf_pkg::*;

    logic [31:0] data_regs [CRF_NUM_DATA];
    logic [31:0] address_regs [CRF_NUM_ADDR];
    logic [31:0] user_stack_pointer;
    logic [31:0] supervisor_stack_pointer;
    logic [31:0] sp_cur;
    logic sup;
    logic addr_wr_ok;
    logic [2:0] wr_idx;
    logic [31:0] rd_raw;
    logic [31:0] idx_raw;

    crf_sw_if swi ();

    crf_status u_status (
        .clock(clock),
        .rst_b(rst_b),
        .swi(swi.unit)
    );

    assign status_word_q = swi.status_word;
    assign sup = swi.status_word[CRF_SW_S_BIT];
    assign supervisor_q = sup;
    assign wr_idx = wr_sel[2:0];
    assign addr_wr_ok = wr_en && wr_sel[3] && (wr_size != CRF_SZ_BYTE); // see RQ4
    assign sp_cur = sup ? supervisor_stack_pointer : user_stack_pointer; // see RQ11

    // flags follow data-register results only
    assign swi.flag_we = wr_en && !wr_sel[3] && wr_flags_en; // see RQ3 see RQ4
    assign swi.flags = wr_flags;
    assign swi.sw_we = sw_wr_en;
    assign swi.sw_full = sw_wr_full;
    assign swi.sw_data = sw_wr_data;

    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] reg_value(input logic [3:0] sel);
        if (!sel[3]) begin
            return data_regs[sel[2:0]];
        end else if (sel == CRF_SP_SEL) begin
            return sp_cur;
        end else begin
            return address_regs[sel[2:0]];
        end
    endfunction

    // whole selected words, sliced by the read paths below
    assign rd_raw = reg_value(rd_sel);
    assign idx_raw = reg_value(idx_sel); // see RQ6

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    for (genvar g = 0; g < CRF_NUM_DATA; g++) begin : g_data
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                data_regs[g] <= CRF_REG_RESET;
            end else if (wr_en && wr_sel == 4'(g)) begin
                case (wr_size) // see RQ2
                    CRF_SZ_BYTE: data_regs[g][7:0] <= wr_data[7:0];
                    CRF_SZ_WORD: data_regs[g][15:0] <= wr_data[15:0];
                    default: data_regs[g] <= wr_data;
                endcase
            end
        end
    end

    // ----------------------------------------
    // address registers
    // ----------------------------------------
    for (genvar g = 0; g < CRF_NUM_ADDR; g++) begin : g_addr
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                address_regs[g] <= CRF_REG_RESET;
            end else if (addr_wr_ok && wr_sel == 4'(8 + g)) begin
                // word writes extend the sign over the whole register
                address_regs[g] <= (wr_size == CRF_SZ_WORD) ? sext16(wr_data[15:0]) : wr_data; // see RQ4
            end
        end
    end

    // ----------------------------------------
    // stack pointers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            user_stack_pointer <= CRF_REG_RESET;
            supervisor_stack_pointer <= CRF_REG_RESET;
        end else if (addr_wr_ok && wr_sel == CRF_SP_SEL) begin
            if (sup) begin
                supervisor_stack_pointer <= (wr_size == CRF_SZ_WORD) ?
                    sext16(wr_data[15:0]) : wr_data; // see RQ7 see RQ11
            end else begin
                user_stack_pointer <= (wr_size == CRF_SZ_WORD) ?
                    sext16(wr_data[15:0]) : wr_data; // see RQ11
            end
        end
    end

    // ----------------------------------------
    // program counter
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= CRF_REG_RESET;
        end else if (pc_load) begin
            pc_q <= pc_data; // see RQ1
        end
    end

    // ----------------------------------------
    // registered reads
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= CRF_REG_RESET;
        end else begin
            case (rd_size) // see RQ2
                CRF_SZ_BYTE: rd_data_q <= {24'h00_0000, rd_raw[7:0]};
                CRF_SZ_WORD: rd_data_q <= {16'h0000, rd_raw[15:0]};
                default: rd_data_q <= rd_raw;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            index_q <= CRF_REG_RESET;
        end else begin
            index_q <= idx_long ? idx_raw : sext16(idx_raw[15:0]); // see RQ6
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            base_addr_q <= CRF_REG_RESET;
        end else if (base_sel == CRF_SP_BASE) begin
            base_addr_q <= sp_cur; // see RQ5 see RQ11
        end else begin
            base_addr_q <= address_regs[base_sel]; // see RQ5
        end
    end

    // ----------------------------------------
    // fault pulses
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            size_fault_q <= 1'b0;
            priv_fault_q <= 1'b0;
        end else begin
            size_fault_q <= wr_en && wr_sel[3] && (wr_size == CRF_SZ_BYTE); // see RQ4
            priv_fault_q <= sw_wr_en && sw_wr_full && !sup; // see RQ7
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_addr_write;
        wr_en && wr_sel[3] && !sw_wr_en;
    endsequence

    sequence s_data_flag_write;
        wr_en && !wr_sel[3] && wr_flags_en && !sw_wr_en;
    endsequence

    a_pc_load_taken: assert property ( // see RQ1
        pc_load |=> pc_q == $past(pc_data))
        else $error("program counter not loaded");
    a_byte_write_merge: assert property ( // see RQ2
        wr_en && !wr_sel[3] && wr_size == CRF_SZ_BYTE |=>
        data_regs[$past(wr_idx)][7:0] == $past(wr_data[7:0]))
        else $error("byte write to data register wrong");
    a_byte_read_zero: assert property ( // see RQ2
        rd_size == CRF_SZ_BYTE |=> rd_data_q[31:8] == 24'h00_0000)
        else $error("byte read not zero-extended");
    a_data_flags_set: assert property ( // see RQ3
        s_data_flag_write |=> status_word_q[4:0] == $past(wr_flags))
        else $error("data write did not update flags");
    a_addr_flags_kept: assert property ( // see RQ4
        s_addr_write |=> $stable(status_word_q[4:0]))
        else $error("address write changed flags");
    a_addr_byte_fault: assert property ( // see RQ4
        wr_en && wr_sel[3] && wr_size == CRF_SZ_BYTE |=> size_fault_q ##1
        (!size_fault_q || $past(wr_en && wr_sel[3] && wr_size == CRF_SZ_BYTE)))
        else $error("byte write to address register not flagged");
    a_index_extend: assert property ( // see RQ6
        !idx_long && !wr_en |=> index_q == sext16($past(idx_raw[15:0])))
        else $error("word index not sign-extended");
    a_sp_resolves: assert property ( // see RQ11
        base_sel == CRF_SP_BASE && sup |=> base_addr_q == $past(supervisor_stack_pointer))
        else $error("stack base not from supervisor pointer");
    a_user_priv_fault: assert property ( // see RQ7
        sw_wr_en && sw_wr_full && !sup |=> priv_fault_q && $stable(status_word_q))
        else $error("user-state status write not refused");
endmodule

// ==== tb/crf_top_tb.sv ====
// Purpose: self-checking bench for the processor register file and status word
// Assumes: inputs change at the falling edge, results are compared at the next falling edge
// Notes: a cycle model in the bench predicts every output from the driven inputs
`timescale 1ns/10ps
module crf_top_tb;
    import crf_pkg::*;
    logic clock, rst_b, wr_en, wr_flags_en, pc_load, sw_wr_en, sw_wr_full, idx_long;
    logic [3:0] wr_sel, rd_sel, idx_sel;
    crf_size_t wr_size, rd_size;
    logic [31:0] wr_data, pc_data, rd_data_q, index_q, base_addr_q, pc_q;
    logic [4:0] wr_flags;
    logic [15:0] sw_wr_data, status_word_q;
    logic [2:0] base_sel;
    logic supervisor_q, size_fault_q, priv_fault_q;
    logic [31:0] m_d [8];
    logic [31:0] m_a [7];
    logic [31:0] m_usp, m_ssp, m_pc, e_rd, e_idx, e_base, lfsr_q;
    logic [15:0] m_sw;
    logic e_sf, e_pf;
    int n_mismatch = 0;
    int num_checks = 0;
    // ----------------------------------------
    // design and clock
    // ----------------------------------------
    crf_top dut_u (.clock(clock), .rst_b(rst_b), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_size(wr_size), .wr_data(wr_data), .wr_flags_en(wr_flags_en),
        .wr_flags(wr_flags), .pc_load(pc_load), .pc_data(pc_data), .sw_wr_en(sw_wr_en),
        .sw_wr_full(sw_wr_full), .sw_wr_data(sw_wr_data), .rd_sel(rd_sel),
        .rd_size(rd_size), .idx_sel(idx_sel), .idx_long(idx_long), .base_sel(base_sel),
        .rd_data_q(rd_data_q), .index_q(index_q), .base_addr_q(base_addr_q),
        .pc_q(pc_q), .status_word_q(status_word_q), .supervisor_q(supervisor_q),
        .size_fault_q(size_fault_q), .priv_fault_q(priv_fault_q));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ----------------------------------------
    // model and checks
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] reg_val(input logic [3:0] sel, input logic s);
        if (!sel[3]) return m_d[sel[2:0]];
        if (sel != 4'hf) return m_a[sel[2:0]];
        return s ? m_ssp : m_usp;
    endfunction
    task automatic model();
        logic s;
        logic [31:0] v;
        if (!rst_b) begin
            foreach (m_d[i]) m_d[i] = 32'h0;
            foreach (m_a[i]) m_a[i] = 32'h0;
            {m_usp, m_ssp, m_pc, e_rd, e_idx, e_base} = '0;
            m_sw = 16'h2700;
            {e_sf, e_pf} = 2'b00;
            return;
        end
        s = m_sw[13];
        v = reg_val(rd_sel, s);
        e_rd = (rd_size == CRF_SZ_BYTE) ? {24'h0, v[7:0]} :
            (rd_size == CRF_SZ_WORD) ? {16'h0, v[15:0]} : v;
        v = reg_val(idx_sel, s);
        e_idx = idx_long ? v : {{16{v[15]}}, v[15:0]};
        e_base = (base_sel == 3'h7) ? (s ? m_ssp : m_usp) : m_a[base_sel];
        e_sf = wr_en && wr_sel[3] && wr_size == CRF_SZ_BYTE;
        e_pf = sw_wr_en && sw_wr_full && !s;
        if (pc_load) m_pc = pc_data;
        v = (wr_size == CRF_SZ_WORD) ? {{16{wr_data[15]}}, wr_data[15:0]} : wr_data;
        if (wr_en && !wr_sel[3]) begin
            if (wr_size == CRF_SZ_BYTE) m_d[wr_sel[2:0]][7:0] = wr_data[7:0];
            else if (wr_size == CRF_SZ_WORD) m_d[wr_sel[2:0]][15:0] = wr_data[15:0];
            else m_d[wr_sel[2:0]] = wr_data;
        end else if (wr_en && !e_sf) begin
            if (wr_sel != 4'hf) m_a[wr_sel[2:0]] = v;
            else if (s) m_ssp = v;
            else m_usp = v;
        end
        if (sw_wr_en) begin
            if (!sw_wr_full) m_sw[7:0] = sw_wr_data[7:0] & 8'h1f;
            else if (s) m_sw = sw_wr_data & 16'ha71f;
        end else if (wr_en && !wr_sel[3] && wr_flags_en) begin
            m_sw[4:0] = wr_flags;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step();
        @(posedge clock);
        model();
        @(negedge clock);
        chk("rd_data_q", e_rd, rd_data_q);
        chk("index_q", e_idx, index_q);
        chk("base_addr_q", e_base, base_addr_q);
        chk("pc_q", m_pc, pc_q);
        chk("status_word_q", {16'h0, m_sw}, {16'h0, status_word_q});
        chk("supervisor_q", {31'h0, m_sw[13]}, {31'h0, supervisor_q});
        chk("size_fault_q", {31'h0, e_sf}, {31'h0, size_fault_q});
        chk("priv_fault_q", {31'h0, e_pf}, {31'h0, priv_fault_q});
    endtask
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    task automatic drive_random();
        logic [31:0] r;
        lfsr_q = lfsr_next(lfsr_q);
        r = lfsr_q;
        {wr_en, pc_load, sw_wr_full, idx_long} = {r[0], r[7], r[11], r[22]};
        wr_sel = r[4:1];
        wr_size = crf_size_t'(r[6] ? 2'h2 : r[6:5]);
        sw_wr_en = (r[10:8] == 3'h0);
        rd_sel = r[15:12];
        rd_size = crf_size_t'(r[17] ? 2'h2 : r[17:16]);
        // address reads only at word or long size
        if (rd_sel[3] && rd_size == CRF_SZ_BYTE) rd_size = CRF_SZ_LONG;
        idx_sel = r[21:18];
        base_sel = r[25:23];
        wr_flags = r[30:26];
        // refused status write never meets a flag update
        wr_flags_en = r[31] & r[0] & ~(sw_wr_en & sw_wr_full & ~m_sw[13]);
        lfsr_q = lfsr_next(lfsr_q);
        r = lfsr_q;
        wr_data = r;
        pc_data = {r[15:0], r[31:16]};
        sw_wr_data = r[15:0] | {2'b00, r[20] | r[21], 13'h0};
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {rst_b, wr_en, wr_flags_en, pc_load, sw_wr_en, sw_wr_full, idx_long} = '0;
        {wr_sel, rd_sel, idx_sel, base_sel, wr_flags} = '0;
        {wr_data, pc_data, sw_wr_data} = '0;
        wr_size = CRF_SZ_BYTE;
        rd_size = CRF_SZ_BYTE;
        lfsr_q = 32'h611f;
        for (int ph = 0; ph < 4; ph++) begin
            rst_b = 1'b0;
            repeat (12) step();
            rst_b = 1'b1;
            // every mask level, then a byte write racing a flag update
            for (int m = 0; m < 8; m++) begin
                {sw_wr_en, sw_wr_full, sw_wr_data} = {2'b11, 16'h2000 | 16'(m << 8)};
                step();
            end
            {wr_en, wr_sel, wr_flags_en, wr_flags, sw_wr_full} = {1'b1, 4'h3, 1'b1, 5'h1f, 1'b0};
            step();
            for (int i = 0; i < 400; i++) begin
                drive_random();
                step();
            end
        end
        final_report();
    end
    initial begin
        #(3000 * 25);
        n_mismatch++;
        final_report();
    end
endmodule
